// ===== core/cob_pkg.sv
`default_nettype none
package cob_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int STORE_W = 80;
  localparam logic [4:0] ESC_PATTERN = 5'h1B;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam int STORE_BIT = 4;
  localparam logic [3:0] BYTES_SHORT = 4'h4;
  localparam logic [3:0] BYTES_LONG = 4'h8;
  localparam logic [3:0] BYTES_TEMP = 4'hA;
  localparam logic [3:0] BYTES_WORD = 4'h2;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } cob_instr_t;

  typedef struct packed {
    logic              addrStrobe;
    logic [ADDR_W-1:0] addr;
    logic              dataStrobe;
    logic [DATA_W-1:0] data;
  } cob_snoop_t;

  typedef struct packed {
    logic              cycle;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        byteEn;
    logic [DATA_W-1:0] data;
  } cob_mst_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_ADDR  = 4'h1,
    S_DUMMY = 4'h3,
    S_COLL  = 4'h2,
    S_REQ   = 4'h6,
    S_WGNT  = 4'h7,
    S_XFER  = 4'h5,
    S_REL   = 4'h4,
    S_EXEC  = 4'hC
  } cob_state_t;

  function automatic logic [3:0] opBytes(input logic [1:0] fmt);
    case (fmt)
      2'h0: opBytes = BYTES_SHORT;
      2'h1: opBytes = BYTES_LONG;
      2'h2: opBytes = BYTES_TEMP;
      default: opBytes = BYTES_WORD;
    endcase
  endfunction

  function automatic logic [1:0] xferSize(input logic wide, input logic a0,
                                          input logic [3:0] left);
    xferSize = (wide && !a0 && left >= BYTES_WORD) ? SIZE_WORD : SIZE_BYTE;
  endfunction

  function automatic logic [7:0] laneByte(input logic wide, input logic a0,
                                          input logic [DATA_W-1:0] d);
    laneByte = (wide && a0) ? d[DATA_W-1 -: BYTE_W] : d[BYTE_W-1:0];
  endfunction
endpackage
`default_nettype wire

// ===== core/cob_operand_bus.sv
// Behaviour
// - Capture and hold the full 20-bit operand address from the host bus.
// - Sign byte sits highest; least significant bytes sit at lowest addresses.
// - Word integer keeps the host's two's-complement byte layout unchanged.
// - On a load, latch the first operand word during the host dummy read.
// - Operands are whole words; longer loads request the bus at once.
// - After grant, run cycles with rising address, then release; a load executes after the release.
// - On a store, both sides ignore data seen during the dummy read.
// - On a store, request the bus only once the result is ready.
// - With an 8-bit host, move one byte per bus cycle.
// - With a 16-bit host, even words take one cycle, odd words two.
// - Odd multiword operands: one byte first, then words, then last byte.
// - A store always targets the address captured at the dummy read.
// - Track the host stream; non-escape instructions are no-operations.
// - Busy stays active while an instruction executes; it feeds host test.
// - Ignore the host sync instruction; host stalls while test is active.
// - The instruction after a sync is decoded by both sides together.
// - Handshake uses single pulses: request, grant, then release.
// - Holding the bus, transfer back to back and release immediately; load cycles pause while the operand buffer is full.
`timescale 1ns/1ps
`default_nettype none
module cob_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0]      count, next_count;
  logic             doWr, doRd;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  always_comb begin
    doWr       = inValid && inReady;
    doRd       = outValid && outReady;
    next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
    next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

module cob_operand_bus (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       busWide16Strap,
  input  wire logic                       instrValid,
  input  wire cob_pkg::cob_instr_t        instr,
  input  wire cob_pkg::cob_snoop_t        snoop,
  input  wire logic                       hbhIn_n,
  output logic                            hbhOut,
  output logic                            hbhOe_n,
  output cob_pkg::cob_mst_t               mst,
  input  wire logic                       mstReady,
  input  wire logic [cob_pkg::DATA_W-1:0] mstRdData,
  output logic                            busy,
  output logic                            execStart,
  output cob_pkg::cob_instr_t             execOp,
  input  wire logic                       execDone,
  output logic      [cob_pkg::DATA_W-1:0] opData,
  output logic                            opValid,
  input  wire logic                       opReady,
  input  wire logic [cob_pkg::DATA_W-1:0] resData,
  input  wire logic                       resValid,
  output logic                            resReady
);
  import cob_pkg::*;

  cob_state_t         state, next_state;
  logic [ADDR_W-1:0]  savedAddr, next_savedAddr, curAddr, next_curAddr;
  logic [3:0]         total, next_total, remain, next_remain;
  logic [2:0]         collected, next_collected;
  logic [STORE_W-1:0] storeBuf, next_storeBuf;
  logic [7:0]         hold, next_hold;
  logic               haveHalf, next_haveHalf, isStore, next_isStore;
  logic               pulse, next_pulse, next_execStart, next_busy;
  cob_instr_t         next_execOp;
  cob_mst_t           next_mst;
  logic               strapMeta, strapSync, wide;
  logic               takeIn, issue, pushValid, pushReady;
  logic [1:0]         inSize, size, ns;
  logic [DATA_W-1:0]  inData, pushWord;
  logic [7:0]         inByte;
  localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;
  logic [FILL_W-1:0]  fill, next_fill;

  // The strap pin is synchronised, sampled while reset is asserted, then held.
  always_ff @(posedge sys_clk) begin
    strapMeta <= busWide16Strap;
    strapSync <= strapMeta;
    if (!rst_n) begin
      wide <= strapSync;
    end
  end

  assign hbhOut   = 1'b0;
  assign hbhOe_n  = !pulse;
  assign resReady = (state == S_COLL);
  assign size     = xferSize(wide, curAddr[0], remain);

  always_comb begin
    next_state     = state;
    next_savedAddr = savedAddr;
    next_curAddr   = curAddr;
    next_total     = total;
    next_remain    = remain;
    next_collected = collected;
    next_storeBuf  = storeBuf;
    next_hold      = hold;
    next_haveHalf  = haveHalf;
    next_isStore   = isStore;
    next_execOp    = execOp;
    next_execStart = 1'b0;
    next_pulse     = 1'b0;
    next_mst       = mst;
    takeIn         = 1'b0;
    issue          = 1'b0;
    inSize         = size;
    inData         = mstRdData;
    pushValid      = 1'b0;
    pushWord       = '0;
    inByte         = '0;
    case (state)
      S_IDLE: begin
        if (instrValid && instr.opcode[7:3] == ESC_PATTERN) begin
          next_execOp  = instr;
          next_isStore = instr.modrm[STORE_BIT];
          next_total   = opBytes(instr.opcode[2:1]);
          if (instr.modrm[7:6] == MOD_REGISTER) begin
            next_execStart = 1'b1;
            next_state     = S_EXEC;
          end else begin
            next_state = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        if (snoop.addrStrobe) begin
          next_savedAddr = snoop.addr;
          next_curAddr   = snoop.addr;
          next_remain    = total;
          next_state     = S_DUMMY;
        end
      end
      S_DUMMY: begin
        inSize = xferSize(wide, curAddr[0], BYTES_WORD - (total - remain));
        inData = snoop.data;
        if (snoop.dataStrobe) begin
          takeIn       = !isStore;
          next_curAddr = curAddr + ADDR_W'(inSize);
          next_remain  = remain - 4'(inSize);
          if (total - next_remain >= BYTES_WORD) begin
            if (isStore) begin
              next_curAddr   = savedAddr;
              next_remain    = total;
              next_collected = '0;
              next_execStart = 1'b1;
              next_state     = S_COLL;
            end else if (next_remain == '0) begin
              next_execStart = 1'b1;
              next_state     = S_EXEC;
            end else begin
              next_state = S_REQ;
            end
          end
        end
      end
      S_COLL: begin
        if (resValid) begin
          next_storeBuf[{collected, 4'h0} +: DATA_W] = resData;
          next_collected = collected + 3'h1;
          if (next_collected == total[3:1]) begin
            next_state = S_REQ;
          end
        end
      end
      S_REQ: begin
        next_pulse = 1'b1;
        next_state = S_WGNT;
      end
      S_WGNT: begin
        if (!hbhIn_n && !pulse) begin
          next_state = S_XFER;
          issue      = 1'b1;
        end
      end
      S_XFER: begin
        if (mst.cycle && mstReady) begin
          takeIn        = !isStore;
          next_curAddr  = curAddr + ADDR_W'(size);
          next_remain   = remain - 4'(size);
          next_storeBuf = storeBuf >> {size, 3'h0};
          if (next_remain == '0) begin
            next_state = S_REL;
          end else begin
            issue = 1'b1;
          end
        end else if (!mst.cycle) begin
          issue = 1'b1;
        end
      end
      S_REL: begin
        next_pulse = 1'b1;
        if (isStore) begin
          next_state = S_IDLE;
        end else begin
          next_execStart = 1'b1;
          next_state     = S_EXEC;
        end
      end
      S_EXEC: begin
        if (execDone) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase

    // low address bytes fill the low half.
    // words kept in host byte order.
    inByte = laneByte(wide, curAddr[0], inData);
    if (takeIn) begin
      if (inSize == SIZE_WORD) begin
        pushValid = 1'b1;
        pushWord  = haveHalf ? {inData[BYTE_W-1:0], hold} : inData;
        next_hold = inData[DATA_W-1 -: BYTE_W];
      end else if (haveHalf) begin
        pushValid     = 1'b1;
        pushWord      = {inByte, hold};
        next_haveHalf = 1'b0;
      end else begin
        next_hold     = inByte;
        next_haveHalf = 1'b1;
      end
    end

    // room for a word in flight.
    next_fill = fill + FILL_W'(pushValid && pushReady) - FILL_W'(opValid && opReady);
    // wide host word or byte cycles.
    ns = xferSize(wide, next_curAddr[0], next_remain);
    if (issue && (isStore || next_fill < FILL_W'(FIFO_DEPTH))) begin
      next_mst.cycle  = 1'b1;
      next_mst.write  = isStore;
      next_mst.addr   = next_curAddr;
      next_mst.byteEn = !wide ? BE_LOW : (ns == SIZE_WORD) ? BE_WORD
                      : (next_curAddr[0] ? BE_HIGH : BE_LOW);
      next_mst.data   = (ns == SIZE_WORD) ? next_storeBuf[DATA_W-1:0]
                      : {2{next_storeBuf[BYTE_W-1:0]}};
    end else if (mstReady || state != S_XFER) begin
      next_mst.cycle = 1'b0;
    end
    next_busy = (next_state != S_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      savedAddr <= '0;
      curAddr   <= '0;
      total     <= '0;
      remain    <= '0;
      collected <= '0;
      storeBuf  <= '0;
      hold      <= '0;
      haveHalf  <= 1'b0;
      isStore   <= 1'b0;
      execOp    <= '0;
      execStart <= 1'b0;
      pulse     <= 1'b0;
      mst       <= '0;
      busy      <= 1'b0;
      fill      <= '0;
    end else begin
      state     <= next_state;
      savedAddr <= next_savedAddr;
      curAddr   <= next_curAddr;
      total     <= next_total;
      remain    <= next_remain;
      collected <= next_collected;
      storeBuf  <= next_storeBuf;
      hold      <= next_hold;
      haveHalf  <= next_haveHalf;
      isStore   <= next_isStore;
      execOp    <= next_execOp;
      execStart <= next_execStart;
      pulse     <= next_pulse;
      mst       <= next_mst;
      busy      <= next_busy;
      fill      <= next_fill;
    end
  end

  cob_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (opValid),
    .outReady (opReady),
    .outData  (opData)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_busy_follows_escape;
    $rose(busy) |-> $past(instrValid) && $past(instr.opcode[7:3]) == ESC_PATTERN;
  endproperty
  a_busy_follows_escape: assert property (p_busy_follows_escape)
    else $error("Busy rose without an escape instruction.");

  property p_non_escape_ignored;
    (state == S_IDLE && instrValid && instr.opcode[7:3] != ESC_PATTERN) |=> !busy;
  endproperty
  a_non_escape_ignored: assert property (p_non_escape_ignored)
    else $error("A non-escape instruction started work.");

  property p_request_single_pulse;
    state == S_REQ |=> !hbhOe_n ##1 hbhOe_n;
  endproperty
  a_request_single_pulse: assert property (p_request_single_pulse)
    else $error("Request pulse is not exactly one cycle.");

  property p_grant_starts_cycle;
    (state == S_WGNT && !hbhIn_n && !pulse && (isStore || pushReady)) |=> mst.cycle;
  endproperty
  a_grant_starts_cycle: assert property (p_grant_starts_cycle)
    else $error("No bus cycle right after the grant.");

  property p_release_after_last;
    (state == S_XFER && mst.cycle && mstReady && remain == 4'(size))
      |=> state == S_REL ##1 !hbhOe_n;
  endproperty
  a_release_after_last: assert property (p_release_after_last)
    else $error("Bus not released right after the last transfer.");

  property p_store_saved_address;
    mst.cycle |-> (mst.addr - savedAddr) < ADDR_W'(total);
  endproperty
  a_store_saved_address: assert property (p_store_saved_address)
    else $error("Bus cycle outside the captured operand.");

  property p_store_dummy_ignored;
    (state == S_DUMMY && isStore) |-> !pushValid;
  endproperty
  a_store_dummy_ignored: assert property (p_store_dummy_ignored)
    else $error("Store dummy-read data reached the operand buffer.");

  property p_narrow_bytes;
    (mst.cycle && !wide) |-> mst.byteEn == BE_LOW;
  endproperty
  a_narrow_bytes: assert property (p_narrow_bytes)
    else $error("Narrow host cycle moved more than one byte.");

  property p_even_word;
    (mst.cycle && wide && !mst.addr[0] && remain >= BYTES_WORD) |-> mst.byteEn == BE_WORD;
  endproperty
  a_even_word: assert property (p_even_word)
    else $error("Even word on a wide host not moved in one cycle.");

  property p_store_waits_result;
    (state == S_REQ && isStore) |-> collected == total[3:1];
  endproperty
  a_store_waits_result: assert property (p_store_waits_result)
    else $error("Store requested the bus before the result was ready.");

  property p_load_request_long;
    (state == S_DUMMY && next_state == S_REQ) |-> !isStore && total > BYTES_WORD;
  endproperty
  a_load_request_long: assert property (p_load_request_long)
    else $error("Bus requested for a one-word load.");

  property p_no_lost_word;
    pushValid |-> pushReady;
  endproperty
  a_no_lost_word: assert property (p_no_lost_word)
    else $error("An operand word met a full buffer.");

  c_long_load: cover property (state == S_XFER && !isStore ##[1:40] state == S_REL);
  c_store: cover property (state == S_XFER && isStore ##[1:40] state == S_REL);
  c_odd_wide: cover property (mst.cycle && wide && mst.addr[0]);
  c_fifo_stall: cover property (state == S_XFER && !pushReady);
endmodule
`default_nettype wire

// ===== bench/cob_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cob_host_model
  import cob_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              wide,
  input  wire logic              slow,
  input  wire logic              hbhOut,
  input  wire logic              hbhOe_n,
  output logic                   hbhIn_n,
  input  wire cob_pkg::cob_mst_t mst,
  output logic                   mstReady,
  output logic      [DATA_W-1:0] mstRdData
);
  logic [7:0] mem [0:1023];
  logic       grant_n;
  logic       owned;
  int         gntWait;
  int         rdyWait;
  logic [9:0] ax;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'(i * 13 + 7);
    grant_n = 1'b1;
    owned = 1'b0;
    gntWait = -1;
    rdyWait = 0;
    mstReady = 1'b0;
    mstRdData = 16'h0000;
  end
  assign hbhIn_n = (hbhOe_n | hbhOut) & grant_n;
  always @(posedge sys_clk) begin
    ax = mst.addr[9:0];
    grant_n <= 1'b1;
    mstReady <= 1'b0;
    mstRdData <= ~mstRdData;
    if (!rst_n) begin
      owned <= 1'b0;
      gntWait = -1;
    end else begin
      if (hbhOe_n === 1'b0 && owned) begin
        owned <= 1'b0;
      end else if (hbhOe_n === 1'b0 && gntWait < 0) begin
        gntWait = slow ? 3 : 0;
      end
      if (gntWait == 0) begin
        grant_n <= 1'b0;
        owned <= 1'b1;
      end
      if (gntWait >= 0) gntWait--;
      if (mst.cycle && !mstReady) begin
        if (rdyWait >= (slow ? 2 : 0)) begin
          mstReady <= 1'b1;
          rdyWait = 0;
          mstRdData <= wide ? {mem[{ax[9:1], 1'b1}], mem[{ax[9:1], 1'b0}]} : {~mem[ax], mem[ax]};
        end else begin
          rdyWait++;
        end
      end
      if (mst.cycle && mstReady && mst.write) begin
        if (!wide) mem[ax] = mst.data[7:0];
        if (wide && mst.byteEn[0]) mem[{ax[9:1], 1'b0}] = mst.data[7:0];
        if (wide && mst.byteEn[1]) mem[{ax[9:1], 1'b1}] = mst.data[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/cob_operand_bus_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cob_operand_bus_tb;
  import cob_pkg::*;
  logic sys_clk, rst_n, wide, slow, instrValid, hbhIn_n, hbhOut, hbhOe_n, mstReady;
  logic busy, execStart, execDone, opValid, opReady, resValid, resReady, expW;
  cob_instr_t        instr;
  cob_instr_t        execOp;
  cob_snoop_t        snoop;
  cob_mst_t          mst;
  logic [DATA_W-1:0] mstRdData, opData, resData;
  logic [ADDR_W-1:0] expA, endA;
  logic [1:0]        en;
  int                err_total, check_count, hsCnt, st;
  logic [DATA_W-1:0] expQ[$];
  logic [DATA_W-1:0] gotQ[$];
  cob_operand_bus DUT (.sys_clk(sys_clk), .rst_n(rst_n), .busWide16Strap(wide),
    .instrValid(instrValid), .instr(instr), .snoop(snoop), .hbhIn_n(hbhIn_n),
    .hbhOut(hbhOut), .hbhOe_n(hbhOe_n), .mst(mst), .mstReady(mstReady),
    .mstRdData(mstRdData), .busy(busy), .execStart(execStart), .execOp(execOp),
    .execDone(execDone), .opData(opData), .opValid(opValid), .opReady(opReady),
    .resData(resData), .resValid(resValid), .resReady(resReady));
  cob_host_model uHost (.sys_clk(sys_clk), .rst_n(rst_n), .wide(wide), .slow(slow),
    .hbhOut(hbhOut), .hbhOe_n(hbhOe_n), .hbhIn_n(hbhIn_n), .mst(mst),
    .mstReady(mstReady), .mstRdData(mstRdData));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (hbhOe_n === 1'b0) hsCnt++;
    if (opValid === 1'b1 && opReady === 1'b1) gotQ.push_back(opData);
    if (mst.cycle === 1'b1 && mstReady === 1'b1) begin
      st = 1;
      en = 2'h1;
      if (wide && expA[0]) en = 2'h2;
      if (wide && !expA[0] && endA - expA >= 2) begin
        en = 2'h3;
        st = 2;
      end
      chk({expW, en, expA}, {mst.write, mst.byteEn, mst.addr});
      expA = expA + ADDR_W'(st);
    end
  end
  task automatic waitFor(input int sel);
    int k;
    k = 0;
    if (sel != 0) begin
      repeat (3) @(negedge sys_clk);
    end
    while (k < 400 && ((sel == 0) ? execStart !== 1'b1 : busy !== 1'b0)) begin
      repeat ((sel == 0) ? 1 : 5) @(negedge sys_clk);
      k++;
    end
    chk(k < 400, 1'b1);
    @(negedge sys_clk);
  endtask
  task automatic issue(input logic [7:0] opc, input logic [7:0] mrm);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instr <= {opc, mrm};
    @(posedge sys_clk);
    instrValid <= 1'b0;
  endtask
  task automatic doReset(input logic w);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    wide <= w;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk({busy, hbhOe_n, mst.cycle, opValid, resReady}, 5'b01000);
  endtask
  // Host dummy read, then stale bus.
  task automatic dummy(input logic [ADDR_W-1:0] a, input logic store);
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = uHost.mem[10'(a)];
    b1 = uHost.mem[10'(a + 1)];
    @(posedge sys_clk);
    snoop.addrStrobe <= 1'b1;
    snoop.addr <= a;
    @(posedge sys_clk);
    snoop.addrStrobe <= 1'b0;
    snoop.dataStrobe <= 1'b1;
    snoop.data <= store ? 16'hDEAD : (wide && a[0]) ? {b0, ~b0} : wide ? {b1, b0} : {~b0, b0};
    if (!wide || a[0]) begin
      @(posedge sys_clk);
      snoop.data <= store ? 16'hBEEF : {~b1, b1};
    end
    @(posedge sys_clk);
    snoop.dataStrobe <= 1'b0;
    snoop.addr <= ~a;
    snoop.data <= 16'h0F0F;
  endtask
  task automatic runLoad(input logic [ADDR_W-1:0] a, input logic [1:0] fmt, input logic hold);
    int n;
    n = (fmt == 2'h0) ? 4 : (fmt == 2'h1) ? 8 : (fmt == 2'h2) ? 10 : 2;
    hsCnt = 0;
    expW = 1'b0;
    expA = a + 20'h2;
    endA = a + ADDR_W'(n);
    for (int i = 0; i < n; i += 2) expQ.push_back({uHost.mem[10'(a+i+1)], uHost.mem[10'(a+i)]});
    issue({ESC_PATTERN, fmt, 1'b0}, 8'h06);
    dummy(a, 1'b0);
    if (hold) begin
      repeat (40) @(negedge sys_clk);
      chk({mst.cycle, opValid}, 2'b01);
      @(posedge sys_clk);
      opReady <= 1'b1;
    end
    waitFor(0);
    chk(expA, endA);
    chk(hsCnt, (n > 2) ? 2 : 0);
    @(posedge sys_clk);
    execDone <= 1'b1;
    @(posedge sys_clk);
    execDone <= 1'b0;
    waitFor(1);
  endtask
  task automatic checkStream();
    int k;
    k = 0;
    while (gotQ.size() < expQ.size() && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    chk(gotQ.size(), expQ.size());
    while (expQ.size() > 0 && gotQ.size() > 0) chk(gotQ.pop_front(), expQ.pop_front());
    gotQ.delete();
    expQ.delete();
  endtask
  task automatic runStore(input logic [ADDR_W-1:0] a, input logic [1:0] fmt);
    int n;
    int i;
    n = (fmt == 2'h0) ? 4 : (fmt == 2'h1) ? 8 : (fmt == 2'h2) ? 10 : 2;
    hsCnt = 0;
    expW = 1'b1;
    expA = a;
    endA = a + ADDR_W'(n);
    issue({ESC_PATTERN, fmt, 1'b0}, 8'h16);
    dummy(a, 1'b1);
    waitFor(0);
    repeat (6) @(negedge sys_clk);
    chk(hsCnt, 0);
    i = 0;
    @(posedge sys_clk);
    resValid <= 1'b1;
    resData <= 16'hA500;
    while (i < n / 2) begin
      @(posedge sys_clk);
      if (resReady === 1'b1) begin
        i++;
        resData <= 16'hA500 + 16'(i);
      end
    end
    resValid <= 1'b0;
    waitFor(1);
    chk(expA, endA);
    chk(hsCnt, 2);
    for (int j = 0; j < n; j++) chk(uHost.mem[10'(a + j)], j[0] ? 8'hA5 : 8'(j / 2));
  endtask
  task automatic t_ignore();
    issue(8'h9B, 8'h00);
    repeat (4) @(negedge sys_clk);
    chk(busy, 1'b0);
    issue({ESC_PATTERN, 3'h0}, 8'hC1);
    @(negedge sys_clk);
    chk({busy, execStart}, 2'b11);
    issue({ESC_PATTERN, 3'h2}, 8'h06);
    repeat (4) @(negedge sys_clk);
    chk({busy, execOp, hsCnt[0]}, {1'b1, ESC_PATTERN, 3'h0, 8'hC1, 1'b0});
    @(posedge sys_clk);
    execDone <= 1'b1;
    @(posedge sys_clk);
    execDone <= 1'b0;
    waitFor(1);
  endtask
  task automatic t_fifo();
    @(posedge sys_clk);
    opReady <= 1'b0;
    for (int i = 0; i < 6; i++) runLoad(20'h00400 + 20'(i * 10), 2'h2, 1'b0);
    runLoad(20'h00480, 2'h2, 1'b1);
    checkStream();
  endtask
  initial begin
    #(8 * 60000);
    err_total++;
    summarize();
  end
  initial begin
    {err_total, check_count, hsCnt, st} = '0;
    {rst_n, instrValid, execDone, resValid, expW, slow} = '0;
    {instr, snoop, resData, expA, endA, en} = '0;
    wide = 1'b1;
    opReady = 1'b1;
    doReset(1'b1);
    t_ignore();
    runLoad(20'hFFF10, 2'h1, 1'b0);
    runLoad(20'h00021, 2'h2, 1'b0);
    runLoad(20'h00040, 2'h3, 1'b0);
    checkStream();
    slow = 1'b1;
    runStore(20'hFFF31, 2'h0);
    runStore(20'h00100, 2'h2);
    t_fifo();
    doReset(1'b0);
    runLoad(20'h00203, 2'h1, 1'b0);
    checkStream();
    runStore(20'h00301, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
